// File: core/readout_mode_consts.svh
/*
  Offsets, field positions, reset values and timing counts of the readout mode register bank.
  Assumes inclusion by bare name from the design module.
*/
`ifndef READOUT_MODE_CONSTS_SVH
`define READOUT_MODE_CONSTS_SVH

// ==========================================================================
// Register offsets (8-bit register addresses)
`define OFS_EXPOSURE_FLASH 8'h1E
`define OFS_READOUT_TWO 8'h20
`define OFS_VSUB 8'h22
`define OFS_HSUB 8'h23
`define OFS_FIRST_GREEN_GAIN 8'h2B
`define OFS_RESTART 8'h0B

// ==========================================================================
// Reset values
`define RST_EXPOSURE_FLASH 16'h4006
`define RST_READOUT_TWO 16'h0040
`define RST_VSUB 16'h0000
`define RST_HSUB 16'h0000
`define RST_FIRST_GREEN_GAIN 16'h0008

// ==========================================================================
// Field positions
`define B_SNAPSHOT 8
`define B_TRIG_EXPOSURE 6
`define B_FLASH_INVERT 5
`define B_FLASH_ENABLE 4
`define B_MIRROR_ROW 15
`define B_MIRROR_COL 14
`define B_DARK_COLS 12
`define B_DARK_ROWS 11
`define B_LINE_BLACK 6
`define B_COL_SUM 5
`define B_MANUAL_OFS 4
`define B_DOUBLER 6
`define B_RESTART 0
`define B_RESTART_PAUSE 1

// ==========================================================================
// Timing
`define ROW_TIME_NS 32'd10000
`define CLK_PERIOD_NS 32'd100
`define ROW_CYCLES (`ROW_TIME_NS / `CLK_PERIOD_NS)
`define RESTART_NS (2 * `ROW_TIME_NS)
`define RESTART_CYCLES (`RESTART_NS / `CLK_PERIOD_NS)

`endif

// File: core/readout_mode_pkg.sv
/*
  Types of the readout mode register bank.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package readout_mode_pkg;

  // ========================================================================
  // Register bus request and answer
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
  } reg_rsp_t;

  // Time points of the flash pulse.
  typedef enum logic [1:0] {
    TP_FIRST_TRIG = 2'h0,
    TP_EXPOSURE = 2'h1,
    TP_SHUTTER = 2'h2,
    TP_SECOND_TRIG = 2'h3
  } time_point_t;

  typedef enum logic [2:0] {
    FL_IDLE = 3'h1,
    FL_ON = 3'h2,
    FL_ROW = 3'h4
  } flash_state_t;

  // Applied readout settings.
  typedef struct packed {
    logic trig_exposure;
    logic snapshot;
    time_point_t flash_start;
    time_point_t flash_end;
    logic mirror_row;
    logic mirror_col;
    logic dark_cols;
    logic dark_rows;
    logic per_line_black_comp;
    logic col_sum;
    logic [1:0] row_bin;
    logic [2:0] row_skip;
    logic [1:0] col_bin;
    logic [2:0] col_skip;
    logic [6:0] first_green_dgain;
    logic first_green_doubler;
  } readout_cfg_t;

endpackage

`default_nettype wire

// File: core/readout_mode_ctrl.sv
/*
  Readout mode register bank of the image sensor: exposure, flash pulse, mirroring,
  dark output, black compensation, binning, skipping and first green gain.
  Assumes a two-wire serial slave decodes host transfers into one-cycle register
  strobes, and that the frame timing core supplies frame, row and time point pulses.
*/
`timescale 1ns/1ns
`default_nettype none
`include "readout_mode_consts.svh"

// Function
// RULE1: Trigger-timed exposure ends by trigger; otherwise shutter width sets exposure.
// RULE2: Flash polarity bit set idles flash high, low during exposure; clear opposite.
// RULE3: Flash enabled generates pulse in integration; disabled holds polarity level.
// RULE4: Flash start code picks assert point: trigger, exposure, shutter, trigger two; reset 1.
// RULE5: Flash end code, reset 2, picks negate point; end not after start gives one row.
// RULE6: Frame-synchronized fields apply only at frame boundary, gated by change sync.
// RULE7: Vertical mirror reads active rows descending; dark rows unchanged; write makes bad frame; code marks only writes that change the bit.
// RULE8: Horizontal mirror reads active columns descending; dark column order unchanged.
// RULE9: Dark column display outputs dark columns left of image, timing unchanged.
// RULE10: Dark row display outputs dark rows first; host then issues a frame restart.
// RULE11: Per-line black compensation, reset on, uses dark average; else fixed offset.
// RULE12: Column summing gives gain of bin factor; clear averages with no gain.
// RULE13: Manual channel offset applies written offsets; clear computes them automatically.
// RULE14: Row bin field gives rows averaged minus one; write causes bad frame.
// RULE15: Row skip gives row pairs skipped; host keeps it at least row bin.
// RULE16: Column bin legal 0, 1, 3; write causes bad frame.
// RULE17: Column skip legal 0 to 6, not below column bin; write causes bad frame.
// RULE18: First green digital gain is one plus value over eight, values 0 to 120.
// RULE19: First green doubler bit adds analog gain of two when set.
// RULE20: Restart abandons frame, resumes first row within two rows; self-clears unless paused.
// RULE21: Single-capture mode waits for trigger between frames; clear runs continuously.

module readout_mode_ctrl (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Register access from the serial slave
  input wire readout_mode_pkg::reg_req_t req_i,
  output readout_mode_pkg::reg_rsp_t rsp_o,
  // Frame timing events
  input wire logic frame_start_i,
  input wire logic row_tick_i,
  input wire logic sync_changes_i,
  input wire logic trigger_first_i,
  input wire logic trigger_second_i,
  input wire logic exposure_start_i,
  input wire logic shutter_done_i,
  // Settings to the readout core
  output readout_mode_pkg::readout_cfg_t cfg_o,
  output logic manual_offset_o,
  output logic exposure_by_trigger_o,
  output logic exposure_end_o,
  output logic wait_trigger_o,
  output logic bad_frame_o,
  output logic restart_o,
  output logic [11:0] first_green_gain_x64_o,
  // Flash pin
  output logic flash_o
);

  // ========================================================================
  // Reset release
  // Reset falls at once but rises only through two flops, so no register of the bank
  // leaves reset on a different edge from its neighbours.
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ========================================================================
  // Host-written shadow registers
  // Host writes land here at once and read back at once; the core sees them via cfg_q, except manual offset and the flash enable and polarity bits, which act live.
  logic [15:0] exp_q;
  logic [15:0] ro2_q;
  logic [15:0] vsub_q;
  logic [15:0] hsub_q;
  logic [15:0] gain_q;
  logic pause_q;
  logic restart_q;
  logic [15:0] restart_cnt_q;
  logic bad_pend_q;

  function automatic logic wr_hit(input readout_mode_pkg::reg_req_t r, input logic [7:0] a);
    wr_hit = r.wr && (r.addr == a);
  endfunction

  always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      exp_q <= `RST_EXPOSURE_FLASH;
      ro2_q <= `RST_READOUT_TWO;
      vsub_q <= `RST_VSUB;
      hsub_q <= `RST_HSUB;
      gain_q <= `RST_FIRST_GREEN_GAIN;
    end else begin
      if (wr_hit(req_i, `OFS_EXPOSURE_FLASH)) begin
        exp_q <= req_i.wdata;
      end
      if (wr_hit(req_i, `OFS_READOUT_TWO)) begin
        ro2_q <= req_i.wdata;
      end
      if (wr_hit(req_i, `OFS_VSUB)) begin
        vsub_q <= req_i.wdata;
      end
      if (wr_hit(req_i, `OFS_HSUB)) begin
        hsub_q <= req_i.wdata;
      end
      if (wr_hit(req_i, `OFS_FIRST_GREEN_GAIN)) begin
        gain_q <= req_i.wdata;
      end
    end
  end

  // Writes that change mirror-row, and any write to binning or skipping fields, spoil the next applied frame.
  logic bad_write;
  always_comb begin
    bad_write = 1'b0;
    if (wr_hit(req_i, `OFS_READOUT_TWO) &&
        (req_i.wdata[`B_MIRROR_ROW] != ro2_q[`B_MIRROR_ROW])) begin
      bad_write = 1'b1; // RULE7
    end
    if (wr_hit(req_i, `OFS_VSUB)) begin
      bad_write = 1'b1; // RULE14
    end
    if (wr_hit(req_i, `OFS_HSUB)) begin
      bad_write = 1'b1; // RULE16 RULE17
    end
  end

  // ========================================================================
  // Frame-boundary application
  readout_mode_pkg::readout_cfg_t shadow;
  readout_mode_pkg::readout_cfg_t cfg_q;
  logic apply;

  // One decoder serves the live shadow and the reset value, so the two cannot drift apart.
  function automatic readout_mode_pkg::readout_cfg_t decode_cfg(input logic [15:0] ef,
      input logic [15:0] r2,
      input logic [15:0] vs,
      input logic [15:0] hs,
      input logic [15:0] gn);
    readout_mode_pkg::readout_cfg_t c;
    c.trig_exposure = ef[`B_TRIG_EXPOSURE];
    c.snapshot = ef[`B_SNAPSHOT];
    c.flash_start = readout_mode_pkg::time_point_t'(ef[3:2]);
    c.flash_end = readout_mode_pkg::time_point_t'(ef[1:0]);
    c.mirror_row = r2[`B_MIRROR_ROW];
    c.mirror_col = r2[`B_MIRROR_COL];
    c.dark_cols = r2[`B_DARK_COLS];
    c.dark_rows = r2[`B_DARK_ROWS];
    c.per_line_black_comp = r2[`B_LINE_BLACK];
    c.col_sum = r2[`B_COL_SUM];
    c.row_bin = vs[5:4];
    c.row_skip = vs[2:0];
    c.col_bin = hs[5:4];
    c.col_skip = hs[2:0];
    c.first_green_dgain = gn[14:8];
    c.first_green_doubler = gn[`B_DOUBLER];
    return c;
  endfunction

  assign shadow = decode_cfg(exp_q, ro2_q, vsub_q, hsub_q, gain_q);

  // While change sync is held, new values wait so that a group lands together.
  assign apply = frame_start_i && !sync_changes_i; // RULE6

  always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cfg_q <= decode_cfg(`RST_EXPOSURE_FLASH, `RST_READOUT_TWO, `RST_VSUB, `RST_HSUB,
                          `RST_FIRST_GREEN_GAIN);
    end else if (apply) begin
      cfg_q <= shadow; // RULE6
    end
  end

  // A spoiling write in the cycle of an apply keeps the flag pending, so that frame's
  // successor is still marked bad instead of the write being lost.
  always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      bad_pend_q <= 1'b0;
      bad_frame_o <= 1'b0;
    end else begin
      if (apply) begin
        bad_frame_o <= bad_pend_q; // RULE14
      end
      if (bad_write) begin
        bad_pend_q <= 1'b1;
      end else if (apply) begin
        bad_pend_q <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Frame restart
  // The counter stands in for two row periods at the fixed row time. With pause set the
  // request stays parked after the count until the host writes the register again.
  always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      restart_q <= 1'b0;
      pause_q <= 1'b0;
      restart_cnt_q <= 16'h0000;
    end else begin
      if (wr_hit(req_i, `OFS_RESTART)) begin
        pause_q <= req_i.wdata[`B_RESTART_PAUSE];
      end
      if (wr_hit(req_i, `OFS_RESTART) && req_i.wdata[`B_RESTART]) begin
        restart_q <= 1'b1; // RULE20
        restart_cnt_q <= 16'(`RESTART_CYCLES - 1);
      end else if (wr_hit(req_i, `OFS_RESTART)) begin
        restart_q <= 1'b0;
      end else if (restart_q && restart_cnt_q != 16'h0000) begin
        restart_cnt_q <= restart_cnt_q - 16'h0001;
      end else if (restart_q && !pause_q) begin
        restart_q <= 1'b0; // RULE20
      end
    end
  end

  // The pulse marks only the first cycle of a request, so a parked request does not repeat it.
  assign restart_o = restart_q && (restart_cnt_q == 16'(`RESTART_CYCLES - 1)); // RULE20

  // ========================================================================
  // Exposure and capture mode
  assign exposure_by_trigger_o = cfg_q.trig_exposure; // RULE1
  assign exposure_end_o = cfg_q.trig_exposure ? trigger_second_i : shutter_done_i; // RULE1
  assign wait_trigger_o = cfg_q.snapshot; // RULE21
  // Manual offset is a live bit; every other mode output follows the applied settings.
  assign manual_offset_o = ro2_q[`B_MANUAL_OFS]; // RULE13
  assign cfg_o = cfg_q; // RULE8 RULE9 RULE10 RULE11 RULE12 RULE15 RULE17

  // Gain times 64 is (8 + dgain) * 8, doubled by the multiplier. At 16x times 2x this
  // reaches 2048, so the output is twelve bits wide.
  logic [11:0] gain_d;
  always_comb begin
    gain_d = ({5'h00, cfg_q.first_green_dgain} + 12'h008) << 3; // RULE18
    if (cfg_q.first_green_doubler) begin
      gain_d = gain_d << 1; // RULE19
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      first_green_gain_x64_o <= 12'h040;
    end else begin
      first_green_gain_x64_o <= gain_d; // RULE18 RULE19
    end
  end

  // ========================================================================
  // Flash pulse
  function automatic logic at_point(input readout_mode_pkg::time_point_t p,
                                    input logic t1, input logic ex,
                                    input logic sh, input logic t2);
    unique case (p)
      readout_mode_pkg::TP_FIRST_TRIG: at_point = t1;
      readout_mode_pkg::TP_EXPOSURE: at_point = ex;
      readout_mode_pkg::TP_SHUTTER: at_point = sh;
      readout_mode_pkg::TP_SECOND_TRIG: at_point = t2;
    endcase
  endfunction

  readout_mode_pkg::flash_state_t fl_q;
  logic [15:0] row_cnt_q;
  logic hit_start;
  logic hit_end;

  assign hit_start = at_point(cfg_q.flash_start, trigger_first_i, exposure_start_i,
                              shutter_done_i, trigger_second_i); // RULE4
  assign hit_end = at_point(cfg_q.flash_end, trigger_first_i, exposure_start_i,
                            shutter_done_i, trigger_second_i); // RULE5

  always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fl_q <= readout_mode_pkg::FL_IDLE;
      row_cnt_q <= 16'h0000;
    end else begin
      unique case (fl_q)
        readout_mode_pkg::FL_IDLE: begin
          if (exp_q[`B_FLASH_ENABLE] && hit_start) begin
            // An end point at or before the start cannot follow it, so one row is timed.
            if (cfg_q.flash_end <= cfg_q.flash_start) begin
              fl_q <= readout_mode_pkg::FL_ROW; // RULE5
              row_cnt_q <= 16'(`ROW_CYCLES - 1);
            end else begin
              fl_q <= readout_mode_pkg::FL_ON;
            end
          end
        end
        // Clearing enable drops a running pulse at once in either active state.
        readout_mode_pkg::FL_ON: begin
          if (hit_end || !exp_q[`B_FLASH_ENABLE]) begin
            fl_q <= readout_mode_pkg::FL_IDLE; // RULE5
          end
        end
        readout_mode_pkg::FL_ROW: begin
          if (row_cnt_q == 16'h0000 || !exp_q[`B_FLASH_ENABLE]) begin
            fl_q <= readout_mode_pkg::FL_IDLE;
          end else begin
            row_cnt_q <= row_cnt_q - 16'h0001;
          end
        end
        default: fl_q <= readout_mode_pkg::FL_IDLE;
      endcase
    end
  end

  // The polarity bit acts at once: it is a pin level, not a frame setting.
  always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      flash_o <= 1'b0;
    end else begin
      flash_o <= exp_q[`B_FLASH_INVERT] ^
                 (exp_q[`B_FLASH_ENABLE] && (fl_q != readout_mode_pkg::FL_IDLE)); // RULE2 RULE3
    end
  end

  // ========================================================================
  // Register read-back, answered in the cycle of the strobe
  // Reads have no side effect, so the answer can be a plain mux on the strobe's address.
  always_comb begin
    rsp_o.ack = req_i.rd || req_i.wr;
    unique case (req_i.addr)
      `OFS_EXPOSURE_FLASH: rsp_o.rdata = exp_q;
      `OFS_READOUT_TWO: rsp_o.rdata = ro2_q;
      `OFS_VSUB: rsp_o.rdata = vsub_q;
      `OFS_HSUB: rsp_o.rdata = hsub_q;
      `OFS_FIRST_GREEN_GAIN: rsp_o.rdata = gain_q;
      `OFS_RESTART: rsp_o.rdata = {14'h0000, pause_q, restart_q};
      default: rsp_o.rdata = 16'h0000;
    endcase
  end

endmodule

`default_nettype wire

// File: tb/readout_mode_monitor.sv
/*
  Port checker of the readout mode register bank.
  Assumes it is bound to readout_mode_ctrl and sees only that module's ports.
*/
`timescale 1ns/1ns
`default_nettype none
module readout_mode_monitor (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Inputs watched
  input wire readout_mode_pkg::reg_req_t req_i,
  input wire logic frame_start_i,
  input wire logic sync_changes_i,
  input wire logic trigger_second_i,
  input wire logic shutter_done_i,
  // Outputs watched
  input wire readout_mode_pkg::readout_cfg_t cfg_o,
  input wire logic exposure_by_trigger_o,
  input wire logic exposure_end_o,
  input wire logic wait_trigger_o,
  input wire logic bad_frame_o,
  input wire logic restart_o,
  input wire logic [11:0] first_green_gain_x64_o,
  input wire logic flash_o
);
  // ==========================================================================
  // Helper logic
  // The flash bits never reach the ports, so they are copied from the writes.
  logic inv_q;
  logic en_q;
  logic apply;
  logic rst_wr;
  assign apply = frame_start_i && !sync_changes_i;
  assign rst_wr = req_i.wr && req_i.addr == 8'h0B && req_i.wdata[0];
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      inv_q <= 1'b0;
      en_q <= 1'b0;
    end else if (req_i.wr && req_i.addr == 8'h1E) begin
      inv_q <= req_i.wdata[5];
      en_q <= req_i.wdata[4];
    end
  end
  function automatic logic [11:0] gx(input logic [6:0] d, input logic m);
    return ({2'h0, d, 3'h0} + 12'h040) << m;
  endfunction
  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);
  sequence restart_wr;
    rst_wr;
  endsequence
  sequence flash_off;
    !en_q [*3];
  endsequence
  cfg_hold_a: assert property (!apply |=> $stable(cfg_o))
    else $error("applied settings moved outside a frame boundary");
  bad_hold_a: assert property (!apply |=> $stable(bad_frame_o))
    else $error("bad frame flag moved outside a frame boundary");
  exp_end_a: assert property (exposure_end_o ==
      (exposure_by_trigger_o ? trigger_second_i : shutter_done_i))
    else $error("exposure end taken from the wrong event");
  mode_copy_a: assert property (wait_trigger_o == cfg_o.snapshot
      && exposure_by_trigger_o == cfg_o.trig_exposure)
    else $error("mode outputs differ from applied settings");
  flash_level_a: assert property (flash_off |-> flash_o == $past(inv_q))
    else $error("disabled flash pin not at polarity level");
  restart_pulse_a: assert property (restart_wr |=> restart_o)
    else $error("restart write gave no restart pulse");
  restart_cause_a: assert property (restart_o |-> $past(rst_wr))
    else $error("restart pulse without restart write");
  gain_calc_a: assert property ($stable(cfg_o) [*2] |-> first_green_gain_x64_o ==
      gx(cfg_o.first_green_dgain, cfg_o.first_green_doubler))
    else $error("first green gain output wrong");
endmodule
bind readout_mode_ctrl readout_mode_monitor readout_mode_monitor_i (.clk_sys_i, .reset_n_i,
  .req_i, .frame_start_i, .sync_changes_i, .trigger_second_i, .shutter_done_i, .cfg_o,
  .exposure_by_trigger_o, .exposure_end_o, .wait_trigger_o, .bad_frame_o, .restart_o,
  .first_green_gain_x64_o, .flash_o);
`default_nettype wire

// File: tb/readout_host_model.sv
/*
  Host model: issues the register strobes that the serial slave would.
  Assumes the testbench calls its tasks by hierarchical name.
*/
`timescale 1ns/1ns
`default_nettype none
module readout_host_model (
  // Clock
  input wire logic clk_sys_i,
  // Register strobes
  output readout_mode_pkg::reg_req_t req_o,
  input wire readout_mode_pkg::reg_rsp_t rsp_i
);
  // ==========================================================================
  // Transfers
  initial req_o = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
      output readout_mode_pkg::reg_rsp_t r);
    @(negedge clk_sys_i);
    req_o = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk_sys_i);
    r = rsp_i;
    @(negedge clk_sys_i);
    // A released bus shows the inverse of its last value, so nothing stale passes.
    req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    readout_mode_pkg::reg_rsp_t r;
    if (a == 8'h23 && (d[5:4] == 2'h2 || d[2:0] == 3'h7 || d[2:0] < {1'b0, d[5:4]})) return;
    if (a == 8'h22 && d[2:0] < {1'b0, d[5:4]}) return;
    xfer(1'b1, a, d, r);
    if (a == 8'h20 && d[11]) xfer(1'b1, 8'h0B, 16'h0001, r);
  endtask
endmodule
`default_nettype wire

// File: tb/sensor_readout_mode_control_tb_top.sv
/*
  Testbench of the readout mode bank: host model, frame events and scenarios.
  Assumes the design, the checker and the host model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module sensor_readout_mode_control_tb_top;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic sync_changes_i = 1'b0;
  logic [4:0] ev = '0;
  readout_mode_pkg::reg_req_t req;
  readout_mode_pkg::reg_rsp_t rsp;
  readout_mode_pkg::readout_cfg_t cfg;
  logic man, ebt, eend, wtrig, bad, rst, flash;
  logic [11:0] gain;
  int n_fail = 0;
  int n_compared = 0;
  always #50 clk_sys_i = ~clk_sys_i;
  readout_host_model readout_host_model_i (.clk_sys_i, .req_o(req), .rsp_i(rsp));
  readout_mode_ctrl readout_mode_ctrl_i (.clk_sys_i, .reset_n_i, .req_i(req), .rsp_o(rsp),
    .frame_start_i(ev[0]), .row_tick_i(1'b0), .sync_changes_i, .trigger_first_i(ev[1]),
    .exposure_start_i(ev[2]), .shutter_done_i(ev[3]), .trigger_second_i(ev[4]),
    .cfg_o(cfg), .manual_offset_o(man), .exposure_by_trigger_o(ebt), .exposure_end_o(eend),
    .wait_trigger_o(wtrig), .bad_frame_o(bad), .restart_o(rst),
    .first_green_gain_x64_o(gain), .flash_o(flash));
  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
    readout_mode_pkg::reg_rsp_t r;
    readout_host_model_i.xfer(1'b0, a, 16'h0000, r);
    chk({r.ack, r.rdata[14:0]}, {1'b1, e[14:0]}, "read");
    chk(r.rdata, e, "read data");
  endtask
  task automatic pulse(input int i);
    @(negedge clk_sys_i);
    ev[i] = 1'b1;
    @(negedge clk_sys_i);
    ev[i] = 1'b0;
  endtask
  task automatic frame(input logic s);
    sync_changes_i = s;
    pulse(0);
    repeat (2) @(negedge clk_sys_i);
    sync_changes_i = 1'b0;
  endtask
  task automatic evchk(input int i, input logic e);
    @(negedge clk_sys_i);
    ev[i] = 1'b1;
    #1;
    chk({15'h0, eend}, {15'h0, e}, "exposure end");
    @(negedge clk_sys_i);
    ev[i] = 1'b0;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    rdchk(8'h1E, 16'h4006);
    rdchk(8'h20, 16'h0040);
    rdchk(8'h22, 16'h0000);
    rdchk(8'h23, 16'h0000);
    rdchk(8'h2B, 16'h0008);
    rdchk(8'h55, 16'h0000);
    chk({4'h0, gain}, 16'h0040, "reset gain");
  endtask
  task automatic t_sync();
    readout_host_model_i.wr(8'h20, 16'h8850);
    readout_host_model_i.wr(8'h22, 16'h0011);
    rdchk(8'h20, 16'h8850);
    chk({15'h0, man}, 16'h0001, "manual offset");
    frame(1'b1);
    chk({15'h0, cfg.mirror_row}, 16'h0000, "held by sync");
    frame(1'b0);
    chk({7'h00, cfg.mirror_row, cfg.dark_rows, cfg.per_line_black_comp, cfg.row_bin,
      cfg.row_skip, bad}, 16'h01D3, "applied");
    frame(1'b0);
    chk({15'h0, bad}, 16'h0000, "bad frame over");
  endtask
  task automatic t_cols();
    readout_host_model_i.wr(8'h20, 16'h5030);
    readout_host_model_i.wr(8'h23, 16'h0013);
    readout_host_model_i.wr(8'h23, 16'h0020);
    rdchk(8'h23, 16'h0013);
    frame(1'b0);
    chk({6'h00, cfg.per_line_black_comp, cfg.mirror_col, cfg.dark_cols, cfg.col_sum,
      cfg.col_bin, cfg.col_skip, bad}, 16'h01D7, "columns");
  endtask
  task automatic t_flash();
    int n;
    for (int c = 0; c < 4; c++) begin
      readout_host_model_i.wr(8'h1E, {11'h000, 1'b1, c[1:0], c[1:0]});
      frame(1'b0);
      pulse(c + 1);
      n = 0;
      while (flash !== 1'b1 && n < 5) begin
        @(negedge clk_sys_i);
        n++;
      end
      chk({15'h0, flash}, 16'h0001, "flash start");
      n = 0;
      while (flash === 1'b1 && n < 200) begin
        @(negedge clk_sys_i);
        n++;
      end
      chk(n[15:0], 16'h0064, "one row pulse");
    end
    readout_host_model_i.wr(8'h1E, 16'h0036);
    frame(1'b0);
    chk({15'h0, flash}, 16'h0001, "inverted idle");
    pulse(2);
    repeat (2) @(negedge clk_sys_i);
    chk({15'h0, flash}, 16'h0000, "inverted active");
    pulse(3);
    repeat (2) @(negedge clk_sys_i);
    chk({15'h0, flash}, 16'h0001, "ended at shutter");
    readout_host_model_i.wr(8'h1E, 16'h0006);
    pulse(2);
    repeat (3) @(negedge clk_sys_i);
    chk({15'h0, flash}, 16'h0000, "disabled level");
  endtask
  task automatic t_expo();
    evchk(3, 1'b1);
    readout_host_model_i.wr(8'h1E, 16'h0146);
    frame(1'b0);
    chk({14'h0, ebt, wtrig}, 16'h0003, "trigger modes");
    evchk(3, 1'b0);
    evchk(4, 1'b1);
  endtask
  task automatic t_gain();
    readout_host_model_i.wr(8'h2B, 16'h0348);
    repeat (3) @(negedge clk_sys_i);
    chk({4'h0, gain}, 16'h0040, "gain held");
    frame(1'b0);
    chk({4'h0, gain}, 16'h00B0, "gain applied");
  endtask
  task automatic t_restart();
    readout_host_model_i.wr(8'h0B, 16'h0001);
    chk({15'h0, rst}, 16'h0001, "restart pulse");
    rdchk(8'h0B, 16'h0001);
    repeat (200) @(negedge clk_sys_i);
    rdchk(8'h0B, 16'h0000);
    readout_host_model_i.wr(8'h0B, 16'h0003);
    repeat (210) @(negedge clk_sys_i);
    rdchk(8'h0B, 16'h0003);
  endtask
  // ==========================================================================
  // Sequence and verdict
  task automatic complete_run();
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk_sys_i);
    reset_n_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    t_reset();
    t_sync();
    t_cols();
    t_flash();
    t_expo();
    t_gain();
    t_restart();
    complete_run();
  end
  // The run needs about 1,000 cycles; 5,000 leaves ample margin.
  initial begin
    #500000;
    n_fail++;
    complete_run();
  end
endmodule
`default_nettype wire
